// ==== hw/sfw_pkg.sv ====
/*
  Constants shared by the flash write-protection block: opcodes, security
  register bit positions, reset values and the block geometry.
  Assumes a 24-bit address space of 64 KB blocks and a byte-wide serial link.
*/
package sfw_pkg;

  // ----------------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------------
  localparam logic [7:0] SFW_OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] SFW_OP_WRITE_SECURITY = 8'h2f;
  localparam logic [7:0] SFW_OP_MODE_SELECT = 8'h68;
  localparam logic [7:0] SFW_OP_SINGLE_LOCK = 8'h36;
  localparam logic [7:0] SFW_OP_SINGLE_UNLOCK = 8'h39;
  localparam logic [7:0] SFW_OP_READ_LOCK = 8'h3c;
  localparam logic [7:0] SFW_OP_GLOBAL_LOCK = 8'h7e;
  localparam logic [7:0] SFW_OP_GLOBAL_UNLOCK = 8'h98;
  localparam logic [7:0] SFW_OP_CLEAR_FAIL = 8'h30;

  // ----------------------------------------------------------------------
  // Security register layout and frame lengths
  // ----------------------------------------------------------------------
  localparam int SFW_BIT_MODE_SEL = 7;
  localparam int SFW_BIT_ERASE_FAIL = 6;
  localparam int SFW_BIT_PROG_FAIL = 5;
  localparam int SFW_BIT_OTP_LOCK = 1;
  localparam int SFW_BIT_FACTORY = 0;
  localparam logic [2:0] SFW_LEN_OPCODE = 3'h1;
  localparam logic [2:0] SFW_LEN_ADDR_CMD = 3'h4;
  localparam logic [2:0] SFW_LEN_MAX = 3'h7;

  // ----------------------------------------------------------------------
  // Geometry and reset values
  // ----------------------------------------------------------------------
  localparam int SFW_BLOCKS = 256;
  localparam int SFW_BLK_MSB = 23;
  localparam int SFW_BLK_LSB = 16;
  localparam logic [3:0] SFW_LEVEL_ALL = 4'h9;
  localparam logic SFW_RST_FAIL = 1'b0;
  localparam logic SFW_RST_LOCK = 1'b1;

endpackage : sfw_pkg

// ==== hw/sfw_serial_shift.sv ====
/*
  Serial front end: synchronises the link pins to CLK, finds the serial
  clock edges, assembles received bytes and shifts a reply byte out.
  Assumes the serial clock is slow enough for at least three CLK cycles
  per half period.
*/
`timescale 1ns/1ps
module sfw_serial_shift
  import sfw_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic si_pin,
  input wire logic wp_n_pin,
  input wire logic tx_load,
  input wire logic [7:0] tx_byte,
  output logic wp_n_sync,
  output logic cs_active,
  output logic cs_rise,
  output logic on_boundary,
  output logic byte_valid,
  output logic [7:0] rx_byte,
  output logic so_bit
);

  logic [2:0] cs_q;
  logic [2:0] sclk_q;
  logic [1:0] si_q;
  logic [1:0] wp_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic so_q;
  logic byte_valid_q;
  wire sclk_rise = sclk_q[1] & ~sclk_q[2];
  wire sclk_fall = ~sclk_q[1] & sclk_q[2];

  // --------------------------------------------------------------------
  // Synchronisers; stage 0 feeds only stage 1.
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_q <= 3'h7;
      sclk_q <= 3'h0;
      si_q <= 2'h0;
      wp_q <= 2'h3;
    end else begin
      cs_q <= {cs_q[1:0], cs_n_pin};
      sclk_q <= {sclk_q[1:0], sclk_pin};
      si_q <= {si_q[0], si_pin};
      wp_q <= {wp_q[0], wp_n_pin};
    end
  end

  // Receive side: bit counter restarts whenever the frame is closed.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= 3'h0;
      rx_q <= 8'h00;
      byte_valid_q <= 1'b0;
    end else begin
      byte_valid_q <= 1'b0;
      if (cs_q[1]) begin
        bit_cnt_q <= 3'h0;
      end else if (sclk_rise) begin
        rx_q <= {rx_q[6:0], si_q[1]};
        bit_cnt_q <= bit_cnt_q + 3'h1;
        byte_valid_q <= (bit_cnt_q == 3'h7);
      end
    end
  end

  // Transmit side: MSB first, each bit launched on a falling serial edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_q <= 8'h00;
      so_q <= 1'b0;
    end else if (tx_load) begin
      tx_q <= tx_byte;
    end else if (!cs_q[1] && sclk_fall) begin
      so_q <= tx_q[7];
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  assign wp_n_sync = wp_q[1];
  assign cs_active = ~cs_q[1];
  assign cs_rise = cs_q[1] & ~cs_q[2];
  assign on_boundary = (bit_cnt_q == 3'h0);
  assign byte_valid = byte_valid_q;
  assign rx_byte = rx_q;
  assign so_bit = so_q;

endmodule : sfw_serial_shift

// ==== hw/sfw_protect.sv ====
/*
  Write-protection core of a serial NOR flash: protection mode select,
  per-block volatile locks, OTP lock-down and program/erase fail flags.
  Assumes non-volatile bits are presented on NV_* inputs by the cell store,
  and that the array engine asks before every program or erase.
*/
// What this block does
// R1 - Erase fail flag in bit six
// R2 - Program fail flag in bit five
// R3 - Security write needs no write enable
// R4 - Security write sets OTP lockdown, then frozen
// R5 - Security write only on byte boundary
// R6 - Mode bit: 0 level, 1 block lock
// R7 - Mode bit set once, never cleared
// R8 - Only one protection scheme active
// R9 - Mode set at power-on locks everything
// R10 - Per-block volatile locks, set at power-up
// R11 - Locked block refuses program and erase
// R12 - Level bits protect array; frozen by pin
// R13 - Protect pin low protects all blocks in block lock mode
// R14 - Lock commands ignored unless mode set
// R15 - Mode select opcode sets bit seven
// R16 - Single lock/unlock by upper address bits
// R17 - Host sends write enable and address
// R18 - Lock commands rejected off byte boundary
// R19 - Lock read returns state after address
// R20 - Lock read one means protected
// R21 - Global lock/unlock sets or clears all
// R22 - Host sends write enable before global
// R23 - Protected target sets the fail flag
// R24 - Fail flags hold until clear command
// R25 - Protected target leaves array unchanged
`timescale 1ns/1ps
module sfw_protect
  import sfw_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic SI,
  input wire logic WP_N,
  input wire logic NV_MODE_SEL,
  input wire logic NV_OTP_LOCK,
  input wire logic NV_FACTORY_LOCK,
  input wire logic STATUS_WRITE_DISABLE,
  input wire logic [3:0] BLOCK_PROTECT_LEVEL,
  input wire logic OP_REQ,
  input wire logic OP_ERASE,
  input wire logic OP_OTP,
  input wire logic [23:0] OP_ADDR,
  input wire logic FAIL_RPT,
  input wire logic FAIL_RPT_ERASE,
  output logic SO,
  output logic SO_OE,
  output logic OP_GRANT,
  output logic OP_DENY,
  output logic LEVEL_BITS_LOCKED,
  output logic [7:0] SECURITY_REG
);

  typedef enum logic [1:0] {SFW_CMD, SFW_ADDR, SFW_REPLY, SFW_SKIP} sfw_state_t;

  sfw_state_t state_q;
  sfw_state_t state_d;
  logic wp_n_sync;
  logic cs_active;
  logic cs_rise;
  logic on_boundary;
  logic byte_valid;
  logic [7:0] rx_byte;
  logic so_bit;
  logic tx_load;
  logic [7:0] tx_byte;
  logic [7:0] opcode_q;
  logic [2:0] nbytes_q;
  logic [23:0] addr_q;
  logic init_q;
  logic mode_q;
  logic otp_lock_q;
  logic factory_q;
  logic erase_fail_q;
  logic prog_fail_q;
  logic wel_q;
  logic so_oe_q;
  logic grant_q;
  logic deny_q;
  logic lvl_locked_q;
  logic [SFW_BLOCKS-1:0] lock_q;

  // --------------------------------------------------------------------
  // Serial front end
  // --------------------------------------------------------------------
  sfw_serial_shift u_shift (
    .clk(CLK),
    .rst_n(RST_N),
    .cs_n_pin(CS_N),
    .sclk_pin(SCLK),
    .si_pin(SI),
    .wp_n_pin(WP_N),
    .tx_load(tx_load),
    .tx_byte(tx_byte),
    .wp_n_sync(wp_n_sync),
    .cs_active(cs_active),
    .cs_rise(cs_rise),
    .on_boundary(on_boundary),
    .byte_valid(byte_valid),
    .rx_byte(rx_byte),
    .so_bit(so_bit)
  );

  // --------------------------------------------------------------------
  // Command decode at frame close
  // --------------------------------------------------------------------
  // A frame executes only when the select rises with no partial byte.
  wire frame_ok = cs_rise & on_boundary; // R5 R18
  wire short_ok = frame_ok & (nbytes_q == SFW_LEN_OPCODE);
  wire addr_ok = frame_ok & (nbytes_q == SFW_LEN_ADDR_CMD);
  wire exec_wel = short_ok & (opcode_q == SFW_OP_WRITE_ENABLE);
  wire exec_scur = short_ok & (opcode_q == SFW_OP_WRITE_SECURITY); // R3
  wire exec_mode = short_ok & (opcode_q == SFW_OP_MODE_SELECT); // R15
  wire exec_clr = short_ok & (opcode_q == SFW_OP_CLEAR_FAIL); // R24
  // Lock commands need mode set and a pending write enable.
  wire lock_gate = mode_q & wel_q; // R14 R17 R22
  wire exec_glock = short_ok & lock_gate & (opcode_q == SFW_OP_GLOBAL_LOCK); // R21
  wire exec_gunlock = short_ok & lock_gate & (opcode_q == SFW_OP_GLOBAL_UNLOCK); // R21
  wire exec_slock = addr_ok & lock_gate & (opcode_q == SFW_OP_SINGLE_LOCK); // R16
  wire exec_sunlock = addr_ok & lock_gate & (opcode_q == SFW_OP_SINGLE_UNLOCK); // R16
  wire exec_lock_any = exec_glock | exec_gunlock | exec_slock | exec_sunlock;
  wire [7:0] cmd_blk = addr_q[SFW_BLK_MSB:SFW_BLK_LSB];
  wire [23:0] addr_next = {addr_q[15:0], rx_byte};

  // Opcode byte chooses the path; unknown opcodes are skipped.
  wire is_addr_op = (rx_byte == SFW_OP_SINGLE_LOCK) | (rx_byte == SFW_OP_SINGLE_UNLOCK)
    | ((rx_byte == SFW_OP_READ_LOCK) & mode_q); // R14
  wire is_short_op = (rx_byte == SFW_OP_WRITE_ENABLE) | (rx_byte == SFW_OP_WRITE_SECURITY)
    | (rx_byte == SFW_OP_MODE_SELECT) | (rx_byte == SFW_OP_CLEAR_FAIL)
    | (rx_byte == SFW_OP_GLOBAL_LOCK) | (rx_byte == SFW_OP_GLOBAL_UNLOCK);
  wire last_addr = byte_valid & (state_q == SFW_ADDR) & (nbytes_q == 3'h3);
  assign tx_load = last_addr & (opcode_q == SFW_OP_READ_LOCK); // R19

  // --------------------------------------------------------------------
  // Protection evaluation
  // --------------------------------------------------------------------
  // Level scheme: level L protects the top 2^(L-1) blocks, 9 and up all.
  function automatic logic level_hit(input logic [3:0] lvl, input logic [7:0] blk);
    logic [8:0] first;
    first = 9'h100;
    if (lvl >= SFW_LEVEL_ALL) begin
      first = 9'h000;
    end else if (lvl != 4'h0) begin
      first = 9'h100 - (9'h001 << (lvl - 4'h1));
    end
    return ({1'b0, blk} >= first);
  endfunction : level_hit

  // Exactly one scheme speaks, chosen by the mode bit.
  function automatic logic blk_protected(input logic [7:0] blk);
    if (mode_q) begin
      return ~wp_n_sync | lock_q[blk]; // R8 R11 R13
    end
    return level_hit(BLOCK_PROTECT_LEVEL, blk); // R8 R12
  endfunction : blk_protected

  wire op_blocked = OP_OTP ? otp_lock_q : blk_protected(OP_ADDR[SFW_BLK_MSB:SFW_BLK_LSB]);
  // The lock state rides in the last bit of the reply byte; the rest read zero.
  assign tx_byte = {7'h00, blk_protected(addr_next[SFW_BLK_MSB:SFW_BLK_LSB])}; // R20

  // --------------------------------------------------------------------
  // Frame sequencer
  // --------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (!cs_active) begin
      state_d = SFW_CMD;
    end else if (byte_valid) begin
      unique case (state_q)
        SFW_CMD: begin
          state_d = is_addr_op ? SFW_ADDR : (is_short_op ? SFW_SKIP : SFW_SKIP);
        end
        SFW_ADDR: begin
          state_d = last_addr ? ((opcode_q == SFW_OP_READ_LOCK) ? SFW_REPLY : SFW_SKIP)
            : SFW_ADDR;
        end
        SFW_REPLY: begin
          state_d = SFW_SKIP;
        end
        SFW_SKIP: begin
          state_d = SFW_SKIP;
        end
      endcase
    end
  end

  // Byte counter saturates so long frames never look like short ones.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= SFW_CMD;
      nbytes_q <= 3'h0;
      opcode_q <= 8'h00;
      addr_q <= 24'h000000;
    end else begin
      state_q <= state_d;
      if (!cs_active) begin
        nbytes_q <= 3'h0;
      end else if (byte_valid && nbytes_q != SFW_LEN_MAX) begin
        nbytes_q <= nbytes_q + 3'h1;
      end
      if (byte_valid && state_q == SFW_CMD) begin
        opcode_q <= rx_byte;
      end
      if (byte_valid && state_q == SFW_ADDR) begin
        addr_q <= addr_next;
      end
    end
  end

  // --------------------------------------------------------------------
  // Security register bits
  // --------------------------------------------------------------------
  // Non-volatile bits are picked up one cycle after reset release, so the
  // reset itself only loads constants.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      init_q <= 1'b0;
      mode_q <= 1'b0; // R6
      otp_lock_q <= 1'b0;
      factory_q <= 1'b0;
    end else begin
      init_q <= 1'b1;
      if (!init_q) begin
        mode_q <= NV_MODE_SEL; // R9
        otp_lock_q <= NV_OTP_LOCK;
        factory_q <= NV_FACTORY_LOCK;
      end else begin
        mode_q <= mode_q | exec_mode; // R7
        otp_lock_q <= otp_lock_q | exec_scur; // R4
      end
    end
  end

  // Fail flags: a new failure in the clearing cycle still sets the flag.
  wire set_pfail = (OP_REQ & ~OP_ERASE & op_blocked) | (FAIL_RPT & ~FAIL_RPT_ERASE); // R2 R23
  wire set_efail = (OP_REQ & OP_ERASE & op_blocked) | (FAIL_RPT & FAIL_RPT_ERASE); // R1 R23

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prog_fail_q <= SFW_RST_FAIL;
      erase_fail_q <= SFW_RST_FAIL;
    end else begin
      prog_fail_q <= set_pfail | (prog_fail_q & ~exec_clr); // R2 R24
      erase_fail_q <= set_efail | (erase_fail_q & ~exec_clr); // R1 R24
    end
  end

  // Write enable latch is consumed by any executed lock command.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wel_q <= 1'b0;
    end else if (exec_wel) begin
      wel_q <= 1'b1;
    end else if (exec_lock_any) begin
      wel_q <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Per-block volatile locks
  // --------------------------------------------------------------------
  // Sector addresses resolve to their enclosing block; the lock is per block.
  generate
    for (genvar b = 0; b < SFW_BLOCKS; b++) begin : g_lock
      wire hit = (cmd_blk == 8'(b));
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          lock_q[b] <= SFW_RST_LOCK; // R10
        end else if (exec_glock || (exec_slock && hit)) begin
          lock_q[b] <= 1'b1; // R16 R21
        end else if (exec_gunlock || (exec_sunlock && hit)) begin
          lock_q[b] <= 1'b0; // R16 R21
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Array access arbitration and pin outputs
  // --------------------------------------------------------------------
  // A blocked request is answered with a deny so the engine never touches
  // the array; it costs one cycle of latency for every request.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      grant_q <= 1'b0;
      deny_q <= 1'b0;
      so_oe_q <= 1'b0;
      lvl_locked_q <= 1'b0;
    end else begin
      grant_q <= OP_REQ & ~op_blocked; // R11 R25
      deny_q <= OP_REQ & op_blocked; // R25
      so_oe_q <= cs_active & (state_d == SFW_REPLY); // R19
      lvl_locked_q <= ~mode_q & STATUS_WRITE_DISABLE & ~wp_n_sync; // R12
    end
  end

  assign SO = so_bit;
  assign SO_OE = so_oe_q;
  assign OP_GRANT = grant_q;
  assign OP_DENY = deny_q;
  assign LEVEL_BITS_LOCKED = lvl_locked_q;
  assign SECURITY_REG = {mode_q, erase_fail_q, prog_fail_q, 3'h0, otp_lock_q, factory_q};

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_mode_cmd;
    exec_mode ##1 init_q;
  endsequence

  a_mode_sticky: assert property (init_q && mode_q |=> mode_q) // R7
    else $error("mode select bit returned to zero");
  a_mode_sets: assert property (s_mode_cmd |-> SECURITY_REG[SFW_BIT_MODE_SEL]) // R15
    else $error("mode select command did not set bit seven");
  a_otp_sticky: assert property (init_q && otp_lock_q |=> otp_lock_q) // R4
    else $error("OTP lockdown bit cleared");
  a_scur_sets: assert property (exec_scur && init_q |=> SECURITY_REG[SFW_BIT_OTP_LOCK]) // R4
    else $error("security write did not lock down OTP");
  a_fail_set_wins: assert property (set_pfail |=> SECURITY_REG[SFW_BIT_PROG_FAIL]) // R2
    else $error("program fail lost");
  a_efail_hold: assert property (erase_fail_q && !exec_clr |=> erase_fail_q) // R24
    else $error("erase fail flag dropped without clear");
  a_efail_set: assert property (set_efail |=> SECURITY_REG[SFW_BIT_ERASE_FAIL]) // R1
    else $error("erase fail not flagged");
  a_wp_all_deny: assert property (OP_REQ && mode_q && !wp_n_sync && !OP_OTP
    |=> OP_DENY && !OP_GRANT) // R13
    else $error("request granted with protect pin low in block mode");
  a_skew_reject: assert property (cs_rise && !on_boundary |-> !exec_lock_any && !exec_scur) // R18
    else $error("command executed off byte boundary");
  a_lock_gate: assert property (!mode_q |-> !exec_lock_any) // R14
    else $error("lock command executed in level mode");
  a_glock_all: assert property (exec_glock |=> &lock_q) // R21
    else $error("global lock left a block open");
  a_deny_one: assert property (OP_REQ |=> OP_GRANT ^ OP_DENY) // R25
    else $error("request answered by neither or both");
  a_reset_locks: assert property ($rose(init_q) |-> &lock_q) // R10
    else $error("locks not all set after reset");

endmodule : sfw_protect

// ==== dv/sfw_host_model.sv ====
/*
  Host controller model that drives the serial command link of sfw_protect.
  Assumes clk is the 8 ns bench clock; SCLK idles low between frames.
*/
`timescale 1ns/1ps
module sfw_host_model
  import sfw_pkg::*;
(
  input wire logic clk,
  input wire logic so,
  input wire logic so_oe,
  output logic cs_n,
  output logic sclk,
  output logic si,
  output logic oe_seen
);
  // Five bench clocks make half of the 80 ns link period.
  localparam int HALF = 5;

  // The link starts idle and deselected.
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
    oe_seen = 1'b0;
  end

  // Shift nbits MSB first, then nrd clocks that capture SO at each rise.
  // A count that is not a multiple of eight ends the frame mid-byte on purpose.
  task automatic frame(input logic [31:0] data, input int nbits, input int nrd,
                       output logic [7:0] rd);
    rd = 8'h00;
    oe_seen = 1'b0;
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = 0; i < nbits + nrd; i++) begin
      sclk = 1'b0;
      si = (i < nbits) ? data[31 - i] : ~si;
      repeat (HALF) @(negedge clk);
      sclk = 1'b1;
      oe_seen = oe_seen | so_oe;
      if (i >= nbits) rd = {rd[6:0], so};
      repeat (HALF) @(negedge clk);
    end
    sclk = 1'b0;
    // A released SI flips so that the device cannot lean on a stale level.
    si = ~si;
    repeat (HALF) @(negedge clk);
    cs_n = 1'b1;
    repeat (12) @(negedge clk);
  endtask : frame

endmodule : sfw_host_model

// ==== dv/tb_serial_flash_write_protection.sv ====
/*
  Self-checking bench for sfw_protect, compared with a behavioural model.
  Assumes sfw_pkg and the host model are compiled before this file.
*/
`timescale 1ns/1ps
module tb_serial_flash_write_protection
  import sfw_pkg::*;
;
  logic CLK, RST_N, CS_N, SCLK, SI, WP_N, SO, SO_OE, OE_SEEN;
  logic NV_MODE_SEL, NV_OTP_LOCK, NV_FACTORY_LOCK, STATUS_WRITE_DISABLE;
  logic OP_REQ, OP_ERASE, OP_OTP, FAIL_RPT, FAIL_RPT_ERASE;
  logic OP_GRANT, OP_DENY, LEVEL_BITS_LOCKED;
  logic [3:0] BLOCK_PROTECT_LEVEL;
  logic [23:0] OP_ADDR;
  logic [7:0] SECURITY_REG, rd;
  logic [31:0] seed;
  logic [255:0] m_lock;
  bit m_mode, m_otp, m_fact, m_ef, m_pf, m_wel;
  int fail_count, n_checks;

  // The 125 MHz clock.
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  sfw_host_model i_host (
    .clk(CLK), .so(SO), .so_oe(SO_OE), .cs_n(CS_N), .sclk(SCLK), .si(SI), .oe_seen(OE_SEEN)
  );

  sfw_protect i_dut (
    .CLK(CLK), .RST_N(RST_N), .CS_N(CS_N), .SCLK(SCLK), .SI(SI), .WP_N(WP_N),
    .NV_MODE_SEL(NV_MODE_SEL), .NV_OTP_LOCK(NV_OTP_LOCK), .NV_FACTORY_LOCK(NV_FACTORY_LOCK),
    .STATUS_WRITE_DISABLE(STATUS_WRITE_DISABLE), .BLOCK_PROTECT_LEVEL(BLOCK_PROTECT_LEVEL),
    .OP_REQ(OP_REQ), .OP_ERASE(OP_ERASE), .OP_OTP(OP_OTP), .OP_ADDR(OP_ADDR),
    .FAIL_RPT(FAIL_RPT), .FAIL_RPT_ERASE(FAIL_RPT_ERASE), .SO(SO), .SO_OE(SO_OE),
    .OP_GRANT(OP_GRANT), .OP_DENY(OP_DENY), .LEVEL_BITS_LOCKED(LEVEL_BITS_LOCKED),
    .SECURITY_REG(SECURITY_REG)
  );

  // ----------------------------------------------------------------------
  // Reference model and helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [7:0] exp_sreg();
    return {m_mode, m_ef, m_pf, 3'h0, m_otp, m_fact};
  endfunction : exp_sreg

  // Level L protects the top 2^(L-1) blocks; nine and above cover all.
  function automatic bit lvl_hit(input int l, input int b);
    if (l == 0) return 1'b0;
    if (l > 8) return 1'b1;
    return b >= 256 - (1 << (l - 1));
  endfunction : lvl_hit

  task automatic do_reset(input bit nv);
    RST_N = 1'b0;
    NV_MODE_SEL = nv;
    NV_OTP_LOCK = nv;
    NV_FACTORY_LOCK = nv;
    {m_mode, m_otp, m_fact, m_ef, m_pf, m_wel} = {nv, nv, nv, 3'h0};
    m_lock = '1;
    repeat (12) @(negedge CLK);
    RST_N = 1'b1;
    repeat (3) @(negedge CLK);
  endtask : do_reset

  // A frame counts only when it ends on the byte count its opcode needs.
  task automatic cmd(input logic [7:0] opc, input logic [23:0] a, input int nb);
    bit whole;
    bit single;
    single = opc == SFW_OP_SINGLE_LOCK || opc == SFW_OP_SINGLE_UNLOCK;
    whole = single ? nb == 32 : nb == 8;
    i_host.frame({opc, a}, nb, 0, rd);
    if (whole && opc == SFW_OP_WRITE_ENABLE) m_wel = 1'b1;
    if (whole && opc == SFW_OP_WRITE_SECURITY) m_otp = 1'b1;
    if (whole && opc == SFW_OP_MODE_SELECT) m_mode = 1'b1;
    if (whole && opc == SFW_OP_CLEAR_FAIL) {m_ef, m_pf} = 2'b00;
    if (whole && m_mode && m_wel && (single || opc inside {8'h7e, 8'h98})) begin
      m_wel = 1'b0;
      if (single) m_lock[a[23:16]] = opc == SFW_OP_SINGLE_LOCK;
      else m_lock = {256{opc == SFW_OP_GLOBAL_LOCK}};
    end
    check(SECURITY_REG, exp_sreg());
  endtask : cmd

  // Array request: answer and fail flag are both due one cycle later.
  task automatic arr_op(input bit er, input bit otp, input logic [23:0] a);
    bit deny;
    @(negedge CLK);
    {OP_REQ, OP_ERASE, OP_OTP, OP_ADDR} = {1'b1, er, otp, a};
    @(negedge CLK);
    OP_REQ = 1'b0;
    if (otp) deny = m_otp;
    else if (m_mode) deny = !WP_N || m_lock[a[23:16]];
    else deny = lvl_hit(int'(BLOCK_PROTECT_LEVEL), int'(a[23:16]));
    m_ef |= deny && er;
    m_pf |= deny && !er;
    check(OP_DENY, deny);
    check(OP_GRANT, !deny);
    check(SECURITY_REG, exp_sreg());
  endtask : arr_op

  task automatic rand_ops(input int n);
    repeat (n) begin
      seed = lfsr(seed);
      arr_op(seed[31], 1'b0, seed[23:0]);
    end
  endtask : rand_ops

  task automatic rd_lock(input logic [23:0] a);
    i_host.frame({SFW_OP_READ_LOCK, a}, 32, 8, rd);
    check(OE_SEEN, m_mode);
    if (m_mode) check(rd, {7'h00, (m_lock[a[23:16]] || !WP_N)});
  endtask : rd_lock

  task automatic fail_rpt(input bit er);
    @(negedge CLK);
    {FAIL_RPT, FAIL_RPT_ERASE} = {1'b1, er};
    @(negedge CLK);
    FAIL_RPT = 1'b0;
    m_ef |= er;
    m_pf |= !er;
    @(negedge CLK);
    check(SECURITY_REG, exp_sreg());
  endtask : fail_rpt

  // The protect pin passes two sync flops, so the flag is looked at a few cycles later.
  task automatic pins(input bit wp, input bit swd);
    WP_N = wp;
    STATUS_WRITE_DISABLE = swd;
    repeat (6) @(negedge CLK);
    check(LEVEL_BITS_LOCKED, !m_mode && swd && !wp);
  endtask : pins

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    {WP_N, STATUS_WRITE_DISABLE, OP_REQ, OP_ERASE, OP_OTP, FAIL_RPT, FAIL_RPT_ERASE} = 7'h40;
    BLOCK_PROTECT_LEVEL = 4'h0;
    OP_ADDR = 24'h0;
    seed = 32'hb538;
    fail_count = 0;
    n_checks = 0;
    do_reset(1'b0);
    check(SECURITY_REG, 8'h00);
    $display("test reset done");
    // Levels 1 to 8 probed at their lowest protected block and the one below; the rest at blocks 128 and 127.
    for (int l = 0; l < 16; l++) begin
      int b;
      BLOCK_PROTECT_LEVEL = 4'(l);
      b = (l == 0 || l > 8) ? 128 : 256 - (1 << (l - 1));
      arr_op(1'b0, 1'b0, {8'(b), 16'h0});
      arr_op(1'b1, 1'b0, {8'(b - 1), 16'h0});
      rand_ops(3);
    end
    for (int k = 0; k < 4; k++) pins(k[0], k[1]);
    fail_rpt(1'b1);
    fail_rpt(1'b0);
    cmd(SFW_OP_CLEAR_FAIL, 24'h0, 8);
    $display("test level protection done");
    BLOCK_PROTECT_LEVEL = 4'h0;
    arr_op(1'b0, 1'b1, 24'h0);
    cmd(SFW_OP_WRITE_SECURITY, 24'h0, 7);
    cmd(SFW_OP_WRITE_SECURITY, 24'h0, 8);
    arr_op(1'b1, 1'b1, 24'h0);
    cmd(SFW_OP_CLEAR_FAIL, 24'h0, 8);
    $display("test otp lockdown done");
    // Lock commands in level mode must leave the locks untouched.
    cmd(SFW_OP_WRITE_ENABLE, 24'h0, 8);
    cmd(SFW_OP_SINGLE_UNLOCK, 24'h120000, 32);
    rd_lock(24'h120000);
    cmd(SFW_OP_MODE_SELECT, 24'h0, 9);
    cmd(SFW_OP_MODE_SELECT, 24'h0, 8);
    pins(1'b0, 1'b1);
    pins(1'b1, 1'b0);
    arr_op(1'b1, 1'b0, 24'h120000);
    rand_ops(8);
    cmd(SFW_OP_WRITE_ENABLE, 24'h0, 8);
    cmd(SFW_OP_SINGLE_UNLOCK, 24'h345000, 32);
    cmd(SFW_OP_SINGLE_UNLOCK, 24'h560000, 32);
    rd_lock(24'h34f000);
    rd_lock(24'h560000);
    arr_op(1'b0, 1'b0, 24'h340000);
    cmd(SFW_OP_WRITE_ENABLE, 24'h0, 8);
    cmd(SFW_OP_SINGLE_UNLOCK, 24'h560000, 31);
    cmd(SFW_OP_WRITE_ENABLE, 24'h0, 8);
    cmd(SFW_OP_SINGLE_LOCK, 24'h340000, 32);
    rd_lock(24'h340000);
    cmd(SFW_OP_WRITE_ENABLE, 24'h0, 8);
    cmd(SFW_OP_GLOBAL_UNLOCK, 24'h0, 8);
    rand_ops(8);
    pins(1'b0, 1'b0);
    rand_ops(4);
    rd_lock(24'h560000);
    pins(1'b1, 1'b0);
    cmd(SFW_OP_WRITE_ENABLE, 24'h0, 8);
    cmd(SFW_OP_GLOBAL_LOCK, 24'h0, 8);
    rand_ops(4);
    $display("test block lock done");
    do_reset(1'b1);
    check(SECURITY_REG, 8'h83);
    rand_ops(6);
    arr_op(1'b0, 1'b1, 24'h0);
    $display("test power-on lock done");
    stop_test();
  end

  // A hung run still ends with a verdict.
  initial begin
    repeat (40000) @(posedge CLK);
    fail_count++;
    stop_test();
  end

endmodule : tb_serial_flash_write_protection
